// ===== rtl/hp_pkg.sv
// processor-hot status register constants and types
//
// Contract
// - host read clears read-to-clear flags
// - extension holds alert low until clear write
// - minimum alert width from 2-bit select
// - writing clear 0 releases alert pin
// - read-only bit reports thermal shutdown triggered
// - seven consecutive load failures set fail flag
// - assist failure latches off until written 0
// - assist exit sets flag, alert low
// - enabled vin trigger sets flag, alert low
// - comparator trigger latched until host read
// - critical current trigger latched until read
// - nominal current trigger latched until read
// - discharge level1 trigger latched until read
// - system voltage trigger latched until read
// - battery removal trigger latched until read
// - adapter removal trigger latched until read
// - register pair resets to b800
package hp_pkg;
   localparam logic [7:0]  ADDR_LO   = 8'h22;
   localparam logic [7:0]  ADDR_HI   = 8'h23;
   localparam logic [15:0] RESET_VAL = 16'hb800;
   localparam logic [7:0]  RD_NONE   = 8'h00;
   // upper byte field positions
   localparam int HI_RSVD   = 7;
   localparam int HI_EXT    = 6;
   localparam int HI_WMSB   = 5;
   localparam int HI_WLSB   = 4;
   localparam int HI_CLR    = 3;
   localparam int HI_THERMAL_SHUTDOWN_FLAG  = 2;
   localparam int HI_FAIL   = 1;
   localparam int HI_EXIT   = 0;
   // lower byte: vin flag on top, profile flags below
   localparam int LO_VIN    = 7;
   localparam int LO_RO_MSB = 6;
   localparam int RO_W      = 7;
   localparam logic [1:0] WSEL_100US = 2'h0;
   localparam logic [1:0] WSEL_1MS   = 2'h1;
   localparam logic [1:0] WSEL_5MS   = 2'h2;
   localparam logic [1:0] WSEL_10MS  = 2'h3;
   // times in ns: 10, 100000, 1000000, 5000000, 10000000
   localparam int CLK_PERIOD_NS = 32'ha;
   localparam int T_100US_NS    = 32'h186a0;
   localparam int T_1MS_NS      = 32'hf4240;
   localparam int T_5MS_NS      = 32'h4c4b40;
   localparam int T_10MS_NS     = 32'h989680;
   // least times, so round up
   localparam int CYC_100US = (T_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_1MS   = (T_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_5MS   = (T_5MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_10MS  = (T_10MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W     = 20;
   localparam int FAIL_W    = 3;
   localparam logic [FAIL_W-1:0] FAIL_LIMIT = 3'h7;
   localparam int SYNC_DEPTH = 3;

   typedef enum logic [2:0] {
      HP_IDLE  = 3'h1,
      HP_TIMED = 3'h2,
      HP_HELD  = 3'h4
   } hp_pstate_t;

   // analog trigger levels, all asynchronous to clk_sys_in
   typedef struct packed {
      logic supplemental_assist_mode;
      logic assist_load_fail;
      logic assist_load_ok;
      logic thermal_shutdown;
      logic vin_regulation;
      logic comparator;
      logic critical_current;
      logic nominal_current;
      logic discharge_level1;
      logic system_voltage;
      logic battery_removal;
      logic adapter_removal;
   } hp_trig_t;
   localparam int TRIG_W = $bits(hp_trig_t);
endpackage

// ===== rtl/hp_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module hp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys_in,
   input  wire logic         rst_b_in,
   // levels
   input  wire logic [W-1:0] din_in,
   output logic      [W-1:0] dout_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } hp_sync_t;

   hp_sync_t s_r;
   hp_sync_t s_nxt;

   generate
      if (W < 1) begin : g_chk
         $error("hp_sync width must be at least one");
      end
   endgenerate

   always_comb begin
      s_nxt    = s_r;
      s_nxt.s1 = din_in;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      // a bit moves only once stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) begin
            s_nxt.stable[i] = s_r.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dout_out = s_r.stable;
endmodule

// ===== rtl/hp_pulse_timer.sv
// down counter that times the minimum alert pulse
`timescale 1ns/1ps
module hp_pulse_timer #(
   parameter int W = hp_pkg::TMR_W
) (
   // clock and reset
   input  wire logic         clk_sys_in,
   input  wire logic         rst_b_in,
   // control
   input  wire logic         start_in,
   input  wire logic [W-1:0] load_in,
   output logic              busy_out
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } hp_tmr_t;

   hp_tmr_t s_r;
   hp_tmr_t s_nxt;

   generate
      if (W < 1) begin : g_chk
         $error("hp_pulse_timer width must be at least one");
      end
   endgenerate

   always_comb begin
      s_nxt = s_r;
      if (start_in) begin
         s_nxt.cnt = load_in;
      end else if (s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - W'(1);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy_out = (s_r.cnt != '0);
endmodule

// ===== rtl/hp_status.sv
// processor-hot status/control register pair and alert pulse logic
`timescale 1ns/1ps
module hp_status #(
   parameter int P_CYC_100US = hp_pkg::CYC_100US,
   parameter int P_CYC_1MS   = hp_pkg::CYC_1MS,
   parameter int P_CYC_5MS   = hp_pkg::CYC_5MS,
   parameter int P_CYC_10MS  = hp_pkg::CYC_10MS
) (
   // clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rst_b_in,
   // register port, one byte per access
   input  wire logic [7:0]       reg_addr_in,
   input  wire logic             reg_wr_in,
   input  wire logic             reg_rd_in,
   input  wire logic [7:0]       reg_wdata_in,
   output logic      [7:0]       reg_rdata_out,
   // analog side
   input  wire hp_pkg::hp_trig_t trig_in,
   input  wire logic             vin_regulation_profile_en_in,
   // alert pin and assist control
   output logic                  processor_hot_n_out,
   output logic                  assist_latch_off_out
);
   localparam int TW = hp_pkg::TMR_W;
   localparam int FW = hp_pkg::FAIL_W;
   localparam int RW = hp_pkg::RO_W;

   typedef struct packed {
      logic                   ext_en;
      logic [1:0]             wsel;
      logic                   clr;
      logic                   thermal_shutdown_flag;
      logic                   fail;
      logic                   exit_f;
      logic                   vin_f;
      logic [RW-1:0]          ro_flags;
      logic [hp_pkg::TRIG_W-1:0] prev;
      logic [FW-1:0]          fail_cnt;
      hp_pkg::hp_pstate_t     pst;
      logic                   tmr_start;
      logic [TW-1:0]          tmr_load;
      logic [7:0]             rdata;
      logic                   pin_n;
      logic                   latch_off;
   } hp_state_t;

   hp_state_t        s_r;
   hp_state_t        s_nxt;
   hp_pkg::hp_trig_t t_now;
   hp_pkg::hp_trig_t t_rise;
   logic [hp_pkg::TRIG_W-1:0] sync_lvl;
   logic             tmr_busy;
   logic [RW-1:0]    ro_rise;
   logic             vin_ev;
   logic             pulse_ev;
   logic             rd_lo;
   logic             rd_hi;
   logic             wr_lo;
   logic             wr_hi;

   generate
      if (P_CYC_100US < 1 || P_CYC_100US >= 2 ** TW ||
          P_CYC_1MS < 1 || P_CYC_1MS >= 2 ** TW ||
          P_CYC_5MS < 1 || P_CYC_5MS >= 2 ** TW ||
          P_CYC_10MS < 1 || P_CYC_10MS >= 2 ** TW) begin : g_chk
         $error("hp_status pulse counts outside timer range");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
      hit = (a == t);
   endfunction

   function automatic logic [TW-1:0] cyc_of(input logic [1:0] sel);
      case (sel)
         hp_pkg::WSEL_100US: cyc_of = TW'(P_CYC_100US);
         hp_pkg::WSEL_1MS:   cyc_of = TW'(P_CYC_1MS);
         hp_pkg::WSEL_5MS:   cyc_of = TW'(P_CYC_5MS);
         default:            cyc_of = TW'(P_CYC_10MS);
      endcase
   endfunction

   function automatic logic [7:0] hi_byte(input hp_state_t s);
      logic [7:0] b;
      b                                  = '0;
      b[hp_pkg::HI_RSVD]                 = hp_pkg::RESET_VAL[8 + hp_pkg::HI_RSVD];
      b[hp_pkg::HI_EXT]                  = s.ext_en;
      b[hp_pkg::HI_WMSB:hp_pkg::HI_WLSB] = s.wsel;
      b[hp_pkg::HI_CLR]                  = s.clr;
      b[hp_pkg::HI_THERMAL_SHUTDOWN_FLAG]                = s.thermal_shutdown_flag;
      b[hp_pkg::HI_FAIL]                 = s.fail;
      b[hp_pkg::HI_EXIT]                 = s.exit_f;
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers and pulse timer

   hp_sync #(
      .W (hp_pkg::TRIG_W)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .din_in     (trig_in),
      .dout_out   (sync_lvl)
   );

   hp_pulse_timer #(
      .W (TW)
   ) u_tmr (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .start_in   (s_r.tmr_start),
      .load_in    (s_r.tmr_load),
      .busy_out   (tmr_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // events and decodes

   assign t_now    = hp_pkg::hp_trig_t'(sync_lvl);
   assign t_rise   = hp_pkg::hp_trig_t'(sync_lvl & ~s_r.prev);
   assign ro_rise  = {t_rise.comparator, t_rise.critical_current,
                      t_rise.nominal_current, t_rise.discharge_level1,
                      t_rise.system_voltage, t_rise.battery_removal,
                      t_rise.adapter_removal};
   assign vin_ev   = t_rise.vin_regulation & vin_regulation_profile_en_in;
   assign pulse_ev = (|ro_rise) | vin_ev;
   assign rd_lo    = reg_rd_in & hit(reg_addr_in, hp_pkg::ADDR_LO);
   assign rd_hi    = reg_rd_in & hit(reg_addr_in, hp_pkg::ADDR_HI);
   assign wr_lo    = reg_wr_in & hit(reg_addr_in, hp_pkg::ADDR_LO);
   assign wr_hi    = reg_wr_in & hit(reg_addr_in, hp_pkg::ADDR_HI);

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_nxt           = s_r;
      s_nxt.prev      = sync_lvl;
      s_nxt.tmr_start = 1'b0;

      // read data is a snapshot taken before any clear
      if (rd_lo) begin
         s_nxt.rdata = {s_r.vin_f, s_r.ro_flags};
      end else if (rd_hi) begin
         s_nxt.rdata = hi_byte(s_r);
      end else if (reg_rd_in) begin
         s_nxt.rdata = hp_pkg::RD_NONE;
      end

      // clears first, sets after, so a coincident trigger survives
      if (rd_lo) begin
         s_nxt.ro_flags = '0;
      end
      if (rd_hi) begin
         s_nxt.thermal_shutdown_flag = 1'b0;
      end
      // clear bit idles at 1 again one cycle after a 0 is written
      if (!s_r.clr) begin
         s_nxt.clr = 1'b1;
      end
      if (wr_hi) begin
         s_nxt.ext_en = reg_wdata_in[hp_pkg::HI_EXT];
         s_nxt.wsel   = reg_wdata_in[hp_pkg::HI_WMSB:hp_pkg::HI_WLSB];
         s_nxt.clr    = reg_wdata_in[hp_pkg::HI_CLR];
         if (!reg_wdata_in[hp_pkg::HI_FAIL]) begin
            s_nxt.fail = 1'b0;
         end
         if (!reg_wdata_in[hp_pkg::HI_EXIT]) begin
            s_nxt.exit_f = 1'b0;
         end
      end
      if (wr_lo && !reg_wdata_in[hp_pkg::LO_VIN]) begin
         s_nxt.vin_f = 1'b0;
      end

      s_nxt.ro_flags = s_nxt.ro_flags | ro_rise;
      if (t_rise.thermal_shutdown) begin
         s_nxt.thermal_shutdown_flag = 1'b1;
      end
      if (vin_ev) begin
         s_nxt.vin_f = 1'b1;
      end

      // consecutive load failures, reset by a success or mode exit
      if (!t_now.supplemental_assist_mode) begin
         s_nxt.fail_cnt = '0;
      end else if (t_rise.assist_load_ok) begin
         s_nxt.fail_cnt = '0;
      end else if (t_rise.assist_load_fail) begin
         if (s_r.fail_cnt == hp_pkg::FAIL_LIMIT - FW'(1)) begin
            s_nxt.fail     = 1'b1;
            s_nxt.fail_cnt = '0;
         end else begin
            s_nxt.fail_cnt = s_r.fail_cnt + FW'(1);
         end
      end
      // any way out of assist mode, including our own latch-off
      if (!t_now.supplemental_assist_mode &&
          s_r.prev[hp_pkg::TRIG_W-1]) begin
         s_nxt.exit_f = 1'b1;
      end

      // alert pulse sequencing
      case (s_r.pst)
         hp_pkg::HP_IDLE: begin
            if (pulse_ev && s_r.ext_en) begin
               s_nxt.pst = hp_pkg::HP_HELD;
            end else if (pulse_ev) begin
               s_nxt.pst       = hp_pkg::HP_TIMED;
               s_nxt.tmr_start = 1'b1;
               s_nxt.tmr_load  = cyc_of(s_r.wsel);
            end
         end
         hp_pkg::HP_TIMED: begin
            // a new trigger restarts the minimum width
            if (pulse_ev) begin
               s_nxt.tmr_start = 1'b1;
               s_nxt.tmr_load  = cyc_of(s_r.wsel);
            end else if (!s_r.tmr_start && !tmr_busy) begin
               s_nxt.pst = hp_pkg::HP_IDLE;
            end
         end
         hp_pkg::HP_HELD: begin
            if (!s_r.clr && !pulse_ev) begin
               s_nxt.pst = hp_pkg::HP_IDLE;
            end
         end
         default: begin
            s_nxt.pst = hp_pkg::HP_IDLE;
         end
      endcase

      s_nxt.pin_n = !((s_nxt.pst != hp_pkg::HP_IDLE) || s_nxt.exit_f ||
                      (s_nxt.vin_f && vin_regulation_profile_en_in));
      s_nxt.latch_off = s_nxt.fail;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         s_r          <= '0;
         s_r.ext_en   <= hp_pkg::RESET_VAL[8 + hp_pkg::HI_EXT];
         s_r.wsel     <= hp_pkg::RESET_VAL[8 + hp_pkg::HI_WMSB:8 + hp_pkg::HI_WLSB];
         s_r.clr      <= hp_pkg::RESET_VAL[8 + hp_pkg::HI_CLR];
         s_r.pst      <= hp_pkg::HP_IDLE;
         s_r.pin_n    <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata_out        = s_r.rdata;
   assign processor_hot_n_out  = s_r.pin_n;
   assign assist_latch_off_out = s_r.latch_off;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   logic [TW-1:0] low_cnt_r;
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in || processor_hot_n_out) begin
         low_cnt_r <= '0;
      end else if (low_cnt_r != '1) begin
         low_cnt_r <= low_cnt_r + TW'(1);
      end
   end

   sequence seq_held_no_clear;
      s_r.pst == hp_pkg::HP_HELD && s_r.clr;
   endsequence

   sequence seq_clear_written;
      s_r.pst == hp_pkg::HP_HELD && !s_r.clr && !pulse_ev && !s_nxt.exit_f &&
      !(s_nxt.vin_f && vin_regulation_profile_en_in);
   endsequence

   a_rd_clear_lo: assert property (
      rd_lo && ro_rise == '0 |=> s_r.ro_flags == '0)
      else $error("low byte read did not clear profile flags");

   a_ext_hold: assert property (
      seq_held_no_clear |=> !processor_hot_n_out)
      else $error("extended alert released without clear");

   a_min_width: assert property (
      $rose(processor_hot_n_out) |-> $past(low_cnt_r) >= TW'(P_CYC_100US) - TW'(1))
      else $error("alert pulse shorter than minimum width");

   a_clear_release: assert property (
      seq_clear_written |=> processor_hot_n_out && s_r.clr)
      else $error("clear write did not release alert");

   a_thermal_shutdown_flag_report: assert property (
      t_rise.thermal_shutdown |=> s_r.thermal_shutdown_flag)
      else $error("thermal shutdown not reported");

   a_fail_set: assert property (
      t_now.supplemental_assist_mode && !t_rise.assist_load_ok &&
      t_rise.assist_load_fail && s_r.fail_cnt == hp_pkg::FAIL_LIMIT - FW'(1) |=> s_r.fail)
      else $error("seventh failure did not set fail flag");

   a_fail_latch: assert property (
      s_r.fail && !(wr_hi && !reg_wdata_in[hp_pkg::HI_FAIL])
      |=> s_r.fail ##0 assist_latch_off_out)
      else $error("assist failure latch lost");

   a_exit_low: assert property (
      s_r.exit_f |-> !processor_hot_n_out)
      else $error("assist exit flag without alert low");

   a_vin_low: assert property (
      vin_ev |=> s_r.vin_f && !processor_hot_n_out)
      else $error("vin trigger did not pull alert low");

   a_ro_keep: assert property (
      |s_r.ro_flags && !rd_lo |=> $past(s_r.ro_flags) == (s_r.ro_flags & $past(s_r.ro_flags)))
      else $error("profile flag dropped without read");

   a_reset_val: assert property (
      $past(!rst_b_in) |-> hi_byte(s_r) == hp_pkg::RESET_VAL[15:8] &&
      {s_r.vin_f, s_r.ro_flags} == hp_pkg::RESET_VAL[7:0])
      else $error("register pair not at reset value");

   a_set_wins: assert property (
      rd_lo && ro_rise != '0 |=> (s_r.ro_flags & $past(ro_rise)) == $past(ro_rise))
      else $error("trigger lost in clearing read");

   a_thermal_shutdown_flag_clear: assert property (
      rd_hi && !t_rise.thermal_shutdown |=> !s_r.thermal_shutdown_flag)
      else $error("high byte read did not clear shutdown bit");

   a_vin_gate: assert property (
      !vin_regulation_profile_en_in && !s_r.vin_f |=> !s_r.vin_f)
      else $error("vin flag set with profile disabled");

   a_timed_start: assert property (
      s_r.pst == hp_pkg::HP_IDLE && pulse_ev && !s_r.ext_en
      |=> s_r.tmr_start && !processor_hot_n_out)
      else $error("timed alert pulse did not start");
endmodule

// ===== bench/hp_trig_model.sv
// trigger source standing in for the analog detectors beside the block
`timescale 1ns/1ps
module hp_trig_model (
   // clock
   input  wire logic        clk_sys_in,
   // commands from the bench
   input  wire logic [10:0] fire_in,
   input  wire logic        assist_mode_in,
   // trigger levels
   output hp_pkg::hp_trig_t trig_out
);
   logic [10:0] lvl_r;
   logic [3:0]  cnt_r;

   initial begin
      lvl_r = 11'h000;
      cnt_r = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // each event held 8 cycles so the agreement filter sees a clean level
   always @(posedge clk_sys_in) begin
      if (fire_in != 11'h000) begin
         lvl_r <= fire_in;
         cnt_r <= 4'h8;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
         if (cnt_r == 4'h1) begin
            lvl_r <= 11'h000;
         end
      end
   end

   assign trig_out = {assist_mode_in, lvl_r};
endmodule

// ===== bench/tb_processor_hot_status_and_pulse.sv
// self-checking bench for the processor-hot status register and alert pulse
`timescale 1ns/1ps
module tb_processor_hot_status_and_pulse;
   // shortened pulse widths in cycles
   localparam int C100 = 4;
   localparam int C1M  = 8;
   localparam int C5M  = 12;
   localparam int C10M = 16;

   logic             clk_sys_in;
   logic             rst_b_in;
   logic [7:0]       reg_addr_in;
   logic             reg_wr_in;
   logic             reg_rd_in;
   logic [7:0]       reg_wdata_in;
   logic [7:0]       reg_rdata_out;
   hp_pkg::hp_trig_t trig;
   logic             vin_en;
   logic             pin_n;
   logic             latch_off;
   logic [10:0]      fire;
   logic             assist_mode;
   int               n_mismatch;
   int               check_count;
   int               cyc_count;

   hp_trig_model partner (
      .clk_sys_in     (clk_sys_in),
      .fire_in        (fire),
      .assist_mode_in (assist_mode),
      .trig_out       (trig)
   );

   hp_status #(
      .P_CYC_100US (C100),
      .P_CYC_1MS   (C1M),
      .P_CYC_5MS   (C5M),
      .P_CYC_10MS  (C10M)
   ) uut (
      .clk_sys_in                   (clk_sys_in),
      .rst_b_in                     (rst_b_in),
      .reg_addr_in                  (reg_addr_in),
      .reg_wr_in                    (reg_wr_in),
      .reg_rd_in                    (reg_rd_in),
      .reg_wdata_in                 (reg_wdata_in),
      .reg_rdata_out                (reg_rdata_out),
      .trig_in                      (trig),
      .vin_regulation_profile_en_in (vin_en),
      .processor_hot_n_out          (pin_n),
      .assist_latch_off_out         (latch_off)
   );

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask

   // data is taken at the edge after the strobe, already settled here
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge clk_sys_in);
      reg_rd_in = 1'b0;
      check({8'h00, reg_rdata_out}, {8'h00, exp});
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge clk_sys_in);
      reg_wr_in = 1'b0;
   endtask

   // wait covers synchroniser, stretch and timed pulses up to C5M cycles, not C10M
   task automatic fire_evt(input int idx);
      @(negedge clk_sys_in);
      fire = 11'h001 << idx;
      @(negedge clk_sys_in);
      fire = 11'h000;
      step(20);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check({15'h0000, pin_n}, 16'h0001);
      rd(8'h22, 8'h00);
      rd(8'h23, 8'hb8);
      rd(8'h40, 8'h00);
      wr(8'h24, 8'hff);
      rd(8'h23, 8'hb8);
   endtask

   task automatic t_flags();
      for (int i = 0; i < 7; i++) begin
         fire_evt(i);
         rd(8'h22, 8'h01 << i);
         rd(8'h22, 8'h00);
      end
      fire_evt(8);
      rd(8'h23, 8'hbc);
      rd(8'h23, 8'hb8);
   endtask

   // read strobe lands on the very edge that latches the trigger
   task automatic t_coincide();
      @(negedge clk_sys_in);
      fire = 11'h001;
      @(negedge clk_sys_in);
      fire = 11'h000;
      step(3);
      rd(8'h22, 8'h00);
      rd(8'h22, 8'h01);
      step(20);
   endtask

   task automatic t_width();
      int cyc [4];
      int n;
      cyc = '{C100, C1M, C5M, C10M};
      for (int s = 0; s < 4; s++) begin
         wr(8'h23, {2'b00, s[1:0], 4'h8});
         @(negedge clk_sys_in);
         fire = 11'h040;
         @(negedge clk_sys_in);
         fire = 11'h000;
         n = 0;
         while (pin_n !== 1'b0 && n < 30) begin
            n++;
            @(negedge clk_sys_in);
         end
         n = 0;
         while (pin_n === 1'b0 && n < 100) begin
            n++;
            @(negedge clk_sys_in);
         end
         check({15'h0000, n >= cyc[s]}, 16'h0001);
         check({15'h0000, n <= cyc[s] + 4}, 16'h0001);
         rd(8'h22, 8'h40);
      end
      rd(8'h23, 8'hb8);
   endtask

   task automatic t_extend();
      wr(8'h23, 8'h78);
      fire_evt(6);
      step(30);
      check({15'h0000, pin_n}, 16'h0000);
      rd(8'h23, 8'hf8);
      wr(8'h23, 8'h70);
      step(2);
      check({15'h0000, pin_n}, 16'h0001);
      rd(8'h23, 8'hf8);
      wr(8'h23, 8'h38);
      rd(8'h22, 8'h40);
   endtask

   // one good load in mid-run restarts the count of failures
   task automatic t_assist();
      @(negedge clk_sys_in);
      assist_mode = 1'b1;
      step(10);
      for (int k = 0; k < 14; k++) begin
         fire_evt(k == 6 ? 9 : 10);
         check({15'h0000, latch_off}, {15'h0000, k == 13});
      end
      rd(8'h23, 8'hba);
      step(30);
      check({15'h0000, latch_off}, 16'h0001);
      wr(8'h23, 8'h38);
      step(2);
      check({15'h0000, latch_off}, 16'h0000);
      assist_mode = 1'b0;
      step(20);
      rd(8'h23, 8'hb9);
      step(30);
      check({15'h0000, pin_n}, 16'h0000);
      wr(8'h23, 8'h38);
      step(25);
      check({15'h0000, pin_n}, 16'h0001);
      rd(8'h23, 8'hb8);
   endtask

   // profile disabled first: the trigger must leave no trace
   task automatic t_vin();
      fire_evt(7);
      check({15'h0000, pin_n}, 16'h0001);
      rd(8'h22, 8'h00);
      vin_en = 1'b1;
      fire_evt(7);
      step(30);
      check({15'h0000, pin_n}, 16'h0000);
      rd(8'h22, 8'h80);
      rd(8'h22, 8'h80);
      wr(8'h22, 8'h00);
      step(25);
      check({15'h0000, pin_n}, 16'h0001);
      rd(8'h22, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys_in) begin
      cyc_count++;
      if (cyc_count == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   initial begin
      n_mismatch = 0;
      check_count = 0;
      cyc_count = 0;
      rst_b_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_wdata_in = 8'h00;
      vin_en = 1'b0;
      fire = 11'h000;
      assist_mode = 1'b0;
      step(12);
      rst_b_in = 1'b1;
      step(4);
      t_reset();
      t_flags();
      t_coincide();
      t_width();
      t_extend();
      t_assist();
      t_vin();
      print_verdict();
   end
endmodule
